// [verilog/snc_config_regs.sv]
// switch node configuration register bank with routing lookup
`timescale 1ns/1ps
`default_nettype none
module snc_config_regs
    import snc_pkg::*;
#(
    parameter logic [7:0] SWITCH_VERSION = 8'h01, // arbitrary value
    parameter logic [7:0] SWITCH_REVISION = 8'h00, // arbitrary value
    parameter logic [7:0] LINK_COUNT = 8'h08,
    parameter logic [7:0] LOCAL_PROCS = 8'h01,
    parameter logic [7:0] DEVICE_PROCS = 8'h02,
    parameter logic [31:0] SCAN_DEVICE_ID = 32'h0000_0001, // arbitrary value
    parameter logic [17:0] FIXED_ID_CODE = 18'h00001 // arbitrary value
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // configuration transactions
    input wire snc_req_t cfgReq,
    output snc_rsp_t cfgRsp,
    // straps and one-time-programmed values
    input wire logic [7:0] bootPins,
    input wire logic [13:0] otpUserCode,
    // debug event sources
    input wire logic dbgEvtProc0,
    input wire logic dbgEvtProc1,
    // routing query
    input wire logic [15:0] routeDestId,
    output logic routeLocal,
    output logic [SNC_DIR_W-1:0] routeDir,
    // control outputs
    output logic headerOneByte,
    output logic [15:0] nodeId,
    output logic [31:0] pllSettings,
    output logic [15:0] switchClkDiv,
    output logic [15:0] refClkDiv,
    output snc_pll_evt_t pllEvent
);
    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [31:0] cfg_q, cfg_d;
    logic [15:0] nodeId_q, nodeId_d;
    logic [31:0] pll_q, pll_d;
    logic [15:0] swDiv_q, swDiv_d;
    logic [15:0] refDiv_q, refDiv_d;
    logic [31:0] dirLo_q, dirLo_d;
    logic [31:0] dirHi_q, dirHi_d;
    logic [31:0] rsvA_q, rsvA_d;
    logic [31:0] rsvB_q, rsvB_d;
    logic [31:0] dbg_q, dbg_d;
    logic [7:0] boot_q;
    logic bootTaken_q;
    snc_rsp_t rsp_q, rsp_d;
    snc_pll_evt_t evt_q, evt_d;
    logic routeLocal_q;
    logic [SNC_DIR_W-1:0] routeDir_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire isWrite = cfgReq.valid && cfgReq.write; // RL20
    wire ctlLocked = cfg_q[SNC_CFG_CTL_LOCK];
    wire pllLocked = cfg_q[SNC_CFG_PLL_LOCK];
    // lock bit itself sits in a control register, so once set it stays set until reset
    wire wrOk = isWrite && !ctlLocked; // RL3
    wire hitCfg = cfgReq.regNum == SNC_REG_CONFIG;
    wire hitNode = cfgReq.regNum == SNC_REG_NODE_ID;
    wire hitPll = cfgReq.regNum == SNC_REG_PLL;
    wire hitSw = cfgReq.regNum == SNC_REG_SW_DIV;
    wire hitRef = cfgReq.regNum == SNC_REG_REF_DIV;
    wire hitDirLo = cfgReq.regNum == SNC_REG_DIR_LO;
    wire hitDirHi = cfgReq.regNum == SNC_REG_DIR_HI;
    wire hitRsvA = cfgReq.regNum == SNC_REG_RSV_A;
    wire hitRsvB = cfgReq.regNum == SNC_REG_RSV_B;
    wire hitDbg = cfgReq.regNum == SNC_REG_DEBUG_SRC;
    wire pllWrite = wrOk && hitPll && !pllLocked; // RL4
    wire [31:0] wd = cfgReq.wdata;

    assign cfg_d = (wrOk && hitCfg) ? (wd & SNC_CFG_MASK) : cfg_q; // RL3 RL4 RL5 RL21
    assign nodeId_d = (wrOk && hitNode) ? wd[15:0] : nodeId_q; // RL6
    assign pll_d = pllWrite ? (wd & SNC_PLL_MASK) : pll_q; // RL12 RL21
    assign swDiv_d = (wrOk && hitSw) ? wd[15:0] : swDiv_q; // RL13
    assign refDiv_d = (wrOk && hitRef) ? wd[15:0] : refDiv_q; // RL14
    assign dirLo_d = (wrOk && hitDirLo) ? wd : dirLo_q; // RL17
    assign dirHi_d = (wrOk && hitDirHi) ? wd : dirHi_q; // RL18
    assign rsvA_d = (wrOk && hitRsvA) ? (wd & SNC_RSV_MASK) : rsvA_q;
    assign rsvB_d = (wrOk && hitRsvB) ? (wd & SNC_RSV_MASK) : rsvB_q;

    // a debug event in the same cycle as a software write wins over the write in bits 1:0
    wire [31:0] dbgWr = (wrOk && hitDbg) ? (wd & SNC_DBG_MASK) : dbg_q;
    wire anyEvt = dbgEvtProc0 || dbgEvtProc1;
    assign dbg_d = anyEvt ? {dbgWr[31:2], dbgEvtProc1, dbgEvtProc0} : dbgWr; // RL19

    // one-cycle pulses for the clock and reset controller
    assign evt_d.tileReset = pllWrite; // RL7
    assign evt_d.chipReset = pllWrite && !wd[SNC_PLL_NO_CHIP_RST]; // RL8
    assign evt_d.waitRelock = pllWrite && !wd[SNC_PLL_NO_RELOCK]; // RL9
    assign evt_d.bypass = pllWrite && wd[SNC_PLL_BYPASS]; // RL10
    assign evt_d.scanBoot = pllWrite && wd[SNC_PLL_SCAN_BOOT]; // RL11

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    logic [31:0] rdMux;
    logic rdHit;
    always_comb
    begin
        rdHit = 1'b1;
        unique case (cfgReq.regNum)
            SNC_REG_IDENT: rdMux = {8'h00, boot_q, SWITCH_REVISION, SWITCH_VERSION}; // RL1
            SNC_REG_DESCR: rdMux = {8'h00, LINK_COUNT, LOCAL_PROCS, DEVICE_PROCS}; // RL2
            SNC_REG_CONFIG: rdMux = cfg_q;
            SNC_REG_NODE_ID: rdMux = {16'h0000, nodeId_q}; // RL21
            SNC_REG_PLL: rdMux = pll_q;
            SNC_REG_SW_DIV: rdMux = {16'h0000, swDiv_q};
            SNC_REG_REF_DIV: rdMux = {16'h0000, refDiv_q};
            SNC_REG_SCAN_ID: rdMux = SCAN_DEVICE_ID;
            SNC_REG_USER_CODE: rdMux = {otpUserCode, FIXED_ID_CODE}; // RL15
            SNC_REG_DIR_LO: rdMux = dirLo_q;
            SNC_REG_DIR_HI: rdMux = dirHi_q;
            SNC_REG_RSV_A: rdMux = rsvA_q;
            SNC_REG_RSV_B: rdMux = rsvB_q;
            SNC_REG_DEBUG_SRC: rdMux = dbg_q;
            default:
            begin
                rdMux = 32'h0000_0000;
                rdHit = 1'b0;
            end
        endcase
    end

    // writes to read-only or unmapped numbers answer not-ok; locked writes too
    wire wrMapped = hitCfg || hitNode || hitPll || hitSw || hitRef || hitDirLo || hitDirHi
        || hitRsvA || hitRsvB || hitDbg;
    wire wrAccepted = wrMapped && wrOk && !(hitPll && pllLocked);
    assign rsp_d.valid = cfgReq.valid;
    assign rsp_d.ok = cfgReq.valid && (cfgReq.write ? wrAccepted : rdHit);
    assign rsp_d.rdata = (cfgReq.valid && !cfgReq.write) ? rdMux : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // routing lookup
    logic lookLocal;
    logic [SNC_DIR_W-1:0] lookDir;
    snc_route_dim #(
        .ID_W(SNC_DIMS)
    ) u_route (
        .ownId(nodeId_q),
        .destId(routeDestId),
        .dirTable({dirHi_q, dirLo_q}),
        .local_(lookLocal),
        .direction(lookDir)
    ); // RL16

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_q <= 32'h0000_0000;
            nodeId_q <= 16'h0000;
            pll_q <= SNC_PLL_RESET;
            swDiv_q <= 16'h0000;
            refDiv_q <= SNC_REF_DIV_RESET;
            dirLo_q <= 32'h0000_0000;
            dirHi_q <= 32'h0000_0000;
            rsvA_q <= 32'h0000_0000;
            rsvB_q <= 32'h0000_0000;
            dbg_q <= 32'h0000_0000;
            rsp_q <= '0;
            evt_q <= '0;
            routeLocal_q <= 1'b0;
            routeDir_q <= 4'h0;
        end
        else
        begin
            cfg_q <= cfg_d;
            nodeId_q <= nodeId_d;
            pll_q <= pll_d;
            swDiv_q <= swDiv_d;
            refDiv_q <= refDiv_d;
            dirLo_q <= dirLo_d;
            dirHi_q <= dirHi_d;
            rsvA_q <= rsvA_d;
            rsvB_q <= rsvB_d;
            dbg_q <= dbg_d;
            rsp_q <= rsp_d;
            evt_q <= evt_d;
            routeLocal_q <= lookLocal;
            routeDir_q <= lookDir;
        end
    end

    // boot pins caught at the first edge after reset release
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            boot_q <= 8'h00;
            bootTaken_q <= 1'b0;
        end
        else if (!bootTaken_q)
        begin
            boot_q <= bootPins; // RL1
            bootTaken_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign cfgRsp = rsp_q;
    assign headerOneByte = cfg_q[SNC_CFG_HDR_ONE]; // RL5
    assign nodeId = nodeId_q;
    assign pllSettings = pll_q;
    assign switchClkDiv = swDiv_q;
    assign refClkDiv = refDiv_q;
    assign pllEvent = evt_q;
    assign routeLocal = routeLocal_q;
    assign routeDir = routeDir_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    ctl_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL3
        (isWrite && ctlLocked) |=> $stable(nodeId_q) && $stable(dirLo_q) && $stable(cfg_q))
        else $error("locked write changed a control register");
    pll_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL4
        (isWrite && hitPll && pllLocked) |=> $stable(pll_q) && !pllEvent.tileReset)
        else $error("pll settings changed while locked");
    hdr_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL5
        (wrOk && hitCfg) |=> headerOneByte == $past(wd[0]))
        else $error("header mode not taken from write");
    node_id_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL6
        (wrOk && hitNode) |=> nodeId == $past(wd[15:0]))
        else $error("node identifier not updated");
    tile_rst_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL7
        pllWrite |=> pllEvent.tileReset ##1 (!pllEvent.tileReset || $past(pllWrite)))
        else $error("tile reset pulse missing");
    chip_rst_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL8
        (pllWrite && wd[31]) |=> !pllEvent.chipReset)
        else $error("chip reset not skipped");
    relock_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL9
        (pllWrite && !wd[30]) |=> pllEvent.waitRelock)
        else $error("relock wait missing");
    bypass_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL10
        pllEvent.bypass |-> pllSettings[29])
        else $error("bypass without settings bit");
    scan_boot_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL11
        pllEvent.scanBoot |-> pllSettings[28])
        else $error("scan boot without settings bit");
    pll_rsvd_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL12 RL21
        (pllSettings & ~SNC_PLL_MASK) == 32'h0000_0000)
        else $error("pll reserved bits set");
    ref_reset_a: assert property (@(posedge sys_clk) // RL14
        $rose(reset_n) |-> refClkDiv == SNC_REF_DIV_RESET)
        else $error("reference divider reset value wrong");
    dbg_src_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL19
        (dbgEvtProc0 && !dbgEvtProc1) |=> dbg_q[1:0] == 2'b01)
        else $error("debug source not recorded");
    rd_answer_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL15 RL20
        (cfgReq.valid && !cfgReq.write && cfgReq.regNum == SNC_REG_USER_CODE)
        |=> cfgRsp.valid && cfgRsp.rdata[17:0] == FIXED_ID_CODE)
        else $error("user code read wrong");

    // answer side
    rsp_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL20
        cfgReq.valid |=> cfgRsp.valid)
        else $error("request not answered");

    rsp_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL20
        !cfgReq.valid |=> !cfgRsp.valid && !cfgRsp.ok)
        else $error("answer without request");

    wr_rdata_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL20
        (cfgReq.valid && cfgReq.write) |=> cfgRsp.rdata == 32'h0000_0000)
        else $error("write answer carries data");

    ident_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL1 RL21
        (cfgReq.valid && !cfgReq.write && cfgReq.regNum == SNC_REG_IDENT)
        |=> cfgRsp.rdata == {8'h00, $past(boot_q), SWITCH_REVISION, SWITCH_VERSION})
        else $error("identity read wrong");

    descr_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL2 RL21
        (cfgReq.valid && !cfgReq.write && cfgReq.regNum == SNC_REG_DESCR)
        |=> cfgRsp.rdata == {8'h00, LINK_COUNT, LOCAL_PROCS, DEVICE_PROCS})
        else $error("description read wrong");

    boot_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL1
        bootTaken_q |=> $stable(boot_q))
        else $error("captured boot pins moved");

    unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL21
        (cfgReq.valid && !cfgReq.write && !rdHit) |=> !cfgRsp.ok && cfgRsp.rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    upper_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL6 RL13 RL14 RL21
        (cfgReq.valid && !cfgReq.write && (hitNode || hitSw || hitRef)) |=> cfgRsp.rdata[31:16] == 16'h0000)
        else $error("reserved upper bits read set");

    // register contents
    cfg_rsvd_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL21
        (cfg_q & ~SNC_CFG_MASK) == 32'h0000_0000)
        else $error("config reserved bits set");

    dbg_rsvd_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL19 RL21
        (dbg_q & ~SNC_DBG_MASK) == 32'h0000_0000)
        else $error("debug reserved bits set");

    sw_div_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL13
        (wrOk && hitSw) |=> switchClkDiv == $past(wd[15:0]))
        else $error("switch clock divider not updated");

    ref_div_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL14
        (wrOk && hitRef) |=> refClkDiv == $past(wd[15:0]))
        else $error("reference divider not updated");

    dir_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL17
        (wrOk && hitDirLo) |=> dirLo_q == $past(wd))
        else $error("low direction table not updated");

    dir_high_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL18
        (wrOk && hitDirHi) |=> dirHi_q == $past(wd))
        else $error("high direction table not updated");

    pll_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL12
        pllWrite |=> pllSettings == ($past(wd) & SNC_PLL_MASK))
        else $error("pll settings not taken from write");

    evt_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL7
        !pllWrite |=> pllEvent == '0)
        else $error("pll event without write");

    dbg_src1_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL19
        (dbgEvtProc1 && !dbgEvtProc0) |=> dbg_q[1:0] == 2'b10)
        else $error("second debug source not recorded");

    // routing lookup, one cycle behind its inputs
    route_local_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL16
        (routeDestId == nodeId_q) |=> routeLocal && routeDir == $past(dirLo_q[3:0]))
        else $error("local destination misrouted");

    route_top_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL16 RL18
        (routeDestId[15] != nodeId_q[15]) |=> !routeLocal && routeDir == $past(dirHi_q[31:28]))
        else $error("top dimension misrouted");

    route_mid_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL16 RL17
        (routeDestId[15:7] == (nodeId_q[15:7] ^ 9'h001)) |=> routeDir == $past(dirLo_q[31:28]))
        else $error("dimension seven misrouted");
endmodule : snc_config_regs
`default_nettype wire

// [pkg/snc_pkg.sv]
// constants, field layouts and carrier types of the switch node configuration registers
// Function
// (RL1) identity: boot pins, revision, version, read-only
// (RL2) description: links, local and total processors
// (RL3) config bit 31 blocks control register writes
// (RL4) config bit 8 blocks pll settings writes
// (RL5) config bit 0 selects one-byte headers
// (RL6) sixteen-bit writable node identifier, reset zero
// (RL7) every pll settings write resets tile
// (RL8) pll bit 31 skips chip reset
// (RL9) pll bit 30 skips waiting for relock
// (RL10) pll bit 29 bypasses the pll
// (RL11) pll bit 28 forces scan-port boot
// (RL12) pll output, feedback and input divider fields
// (RL13) switch clock divider sixteen bits, reset zero
// (RL14) reference clock divider sixteen bits, reset three
// (RL15) user code: programmed code and fixable id
// (RL16) route by most significant mismatching identifier bit
// (RL17) low direction register: dimensions zero to seven
// (RL18) high direction register: dimensions eight to fifteen
// (RL19) debug source bits name last debug processor
// (RL20) reached only by configuration read/write transactions
// (RL21) reserved bits zero; blocked writes change nothing
package snc_pkg;
    localparam logic [7:0] SNC_REG_IDENT = 8'h00;
    localparam logic [7:0] SNC_REG_DESCR = 8'h01;
    localparam logic [7:0] SNC_REG_CONFIG = 8'h04;
    localparam logic [7:0] SNC_REG_NODE_ID = 8'h05;
    localparam logic [7:0] SNC_REG_PLL = 8'h06;
    localparam logic [7:0] SNC_REG_SW_DIV = 8'h07;
    localparam logic [7:0] SNC_REG_REF_DIV = 8'h08;
    localparam logic [7:0] SNC_REG_SCAN_ID = 8'h09;
    localparam logic [7:0] SNC_REG_USER_CODE = 8'h0a;
    localparam logic [7:0] SNC_REG_DIR_LO = 8'h0c;
    localparam logic [7:0] SNC_REG_DIR_HI = 8'h0d;
    localparam logic [7:0] SNC_REG_RSV_A = 8'h10;
    localparam logic [7:0] SNC_REG_RSV_B = 8'h11;
    localparam logic [7:0] SNC_REG_DEBUG_SRC = 8'h1f;
    localparam int SNC_CFG_CTL_LOCK = 31;
    localparam int SNC_CFG_PLL_LOCK = 8;
    localparam int SNC_CFG_HDR_ONE = 0;
    localparam logic [31:0] SNC_CFG_MASK = 32'h8000_0101;
    localparam int SNC_PLL_NO_CHIP_RST = 31;
    localparam int SNC_PLL_NO_RELOCK = 30;
    localparam int SNC_PLL_BYPASS = 29;
    localparam int SNC_PLL_SCAN_BOOT = 28;
    localparam logic [31:0] SNC_PLL_MASK = 32'hf39f_ff7f;
    localparam logic [31:0] SNC_PLL_RESET = 32'h0000_0000;
    localparam logic [31:0] SNC_LOW16_MASK = 32'h0000_ffff;
    localparam logic [31:0] SNC_RSV_MASK = 32'h0000_0003;
    localparam logic [31:0] SNC_DBG_MASK = 32'h0000_0013;
    localparam logic [15:0] SNC_REF_DIV_RESET = 16'h0003;
    localparam int SNC_DIR_W = 4;
    localparam int SNC_DIMS = 16;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic [7:0] regNum;
        logic [31:0] wdata;
    } snc_req_t;

    typedef struct packed
    {
        logic valid;
        logic ok;
        logic [31:0] rdata;
    } snc_rsp_t;

    typedef struct packed
    {
        logic tileReset;
        logic chipReset;
        logic waitRelock;
        logic bypass;
        logic scanBoot;
    } snc_pll_evt_t;
endpackage : snc_pkg

// [verilog/snc_route_dim.sv]
// most significant mismatching identifier bit and its direction
`timescale 1ns/1ps
`default_nettype none
module snc_route_dim
    import snc_pkg::*;
#(
    parameter int ID_W = 16
)
(
    // identifiers
    input wire logic [ID_W-1:0] ownId,
    input wire logic [ID_W-1:0] destId,
    // direction table
    input wire logic [ID_W*SNC_DIR_W-1:0] dirTable,
    // result
    output logic local_,
    output logic [SNC_DIR_W-1:0] direction
);
    logic [ID_W-1:0] diff;
    logic [3:0] dim;

    assign diff = ownId ^ destId;
    assign local_ = (diff == '0);

    always_comb
    begin
        dim = 4'h0;
        for (int i = 0; i < ID_W; i++)
        begin
            if (diff[i])
            begin
                dim = 4'(i); // RL16
            end
        end
    end

    assign direction = dirTable[dim*SNC_DIR_W +: SNC_DIR_W]; // RL16
endmodule : snc_route_dim
`default_nettype wire

// [verification/snc_cfg_host.sv]
// configuration transaction source standing in for processors or the debug host
`timescale 1ns/1ps
`default_nettype none
module snc_cfg_host
    import snc_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // configuration transactions
    output snc_req_t cfgReq,
    input wire snc_rsp_t cfgRsp
);
    initial cfgReq = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // one word per transaction, answer sampled while it stands
    task automatic xfer(input logic wr, input logic [7:0] rn, input logic [31:0] wd,
        output logic [31:0] rd, output logic [1:0] st);
        @(negedge sys_clk);
        cfgReq <= '{valid: 1'b1, write: wr, regNum: rn, wdata: wd};
        @(negedge sys_clk);
        rd = cfgRsp.rdata;
        st = {cfgRsp.valid, cfgRsp.ok};
        // released fields show the inverse so a stale value cannot pass for a live one
        cfgReq <= '{valid: 1'b0, write: ~wr, regNum: ~rn, wdata: ~wd};
    endtask : xfer
endmodule : snc_cfg_host
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the switch node configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import snc_pkg::*;
;
    localparam logic [7:0] VER = 8'h21; // arbitrary value
    localparam logic [7:0] REV = 8'h07; // arbitrary value
    localparam logic [7:0] LINKS = 8'h04;
    localparam logic [7:0] LPROC = 8'h02;
    localparam logic [7:0] DPROC = 8'h03;
    localparam logic [31:0] SCANID = 32'h0000_5a5b; // arbitrary value
    localparam logic [17:0] FIXID = 18'h2c3d1; // arbitrary value
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] bootPins = 8'ha5;
    logic [13:0] otpUserCode = 14'h2a5c;
    logic dbgEvtProc0 = 1'b0;
    logic dbgEvtProc1 = 1'b0;
    logic [15:0] routeDestId = 16'h0000;
    snc_req_t cfgReq;
    snc_rsp_t cfgRsp;
    logic routeLocal;
    logic [3:0] routeDir;
    logic headerOneByte;
    logic [15:0] nodeId, switchClkDiv, refClkDiv;
    logic [31:0] pllSettings;
    snc_pll_evt_t pllEvent;
    logic [31:0] rd;
    logic [1:0] st;
    int num_errors = 0;
    int check_count = 0;

    always #20 sys_clk = ~sys_clk;

    snc_cfg_host u_host (.sys_clk(sys_clk), .cfgReq(cfgReq), .cfgRsp(cfgRsp));
    snc_config_regs #(.SWITCH_VERSION(VER), .SWITCH_REVISION(REV), .LINK_COUNT(LINKS), .LOCAL_PROCS(LPROC),
        .DEVICE_PROCS(DPROC), .SCAN_DEVICE_ID(SCANID), .FIXED_ID_CODE(FIXID)) u_dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .cfgReq(cfgReq), .cfgRsp(cfgRsp), .bootPins(bootPins), .otpUserCode(otpUserCode),
        .dbgEvtProc0(dbgEvtProc0), .dbgEvtProc1(dbgEvtProc1), .routeDestId(routeDestId),
        .routeLocal(routeLocal), .routeDir(routeDir), .headerOneByte(headerOneByte), .nodeId(nodeId),
        .pllSettings(pllSettings), .switchClkDiv(switchClkDiv), .refClkDiv(refClkDiv), .pllEvent(pllEvent));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic acc(input logic wr, input logic [7:0] rn, input logic [31:0] wd, input logic okExp);
        u_host.xfer(wr, rn, wd, rd, st);
        check("response", 32'(st), {30'h0, 1'b1, okExp});
    endtask : acc

    task automatic rdchk(input logic [7:0] rn, input logic [31:0] exp, input logic okExp);
        acc(1'b0, rn, 32'h0, okExp);
        check("rdata", rd, exp);
    endtask : rdchk

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        // pins move after capture; identity must keep the captured level
        @(negedge sys_clk);
        bootPins = 8'h3c;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk(SNC_REG_IDENT, {8'h00, 8'ha5, REV, VER}, 1'b1);
        rdchk(SNC_REG_DESCR, {8'h00, LINKS, LPROC, DPROC}, 1'b1);
        rdchk(SNC_REG_CONFIG, 32'h0, 1'b1);
        rdchk(SNC_REG_NODE_ID, 32'h0, 1'b1);
        rdchk(SNC_REG_PLL, SNC_PLL_RESET, 1'b1);
        rdchk(SNC_REG_SW_DIV, 32'h0, 1'b1);
        rdchk(SNC_REG_REF_DIV, 32'h3, 1'b1);
        rdchk(SNC_REG_SCAN_ID, SCANID, 1'b1);
        rdchk(SNC_REG_USER_CODE, {otpUserCode, FIXID}, 1'b1);
        rdchk(SNC_REG_DIR_LO, 32'h0, 1'b1);
        rdchk(SNC_REG_DIR_HI, 32'h0, 1'b1);
        rdchk(SNC_REG_RSV_A, 32'h0, 1'b1);
        rdchk(SNC_REG_RSV_B, 32'h0, 1'b1);
    endtask : t_reset

    task automatic t_masks();
        logic [7:0] regs [8] = '{SNC_REG_NODE_ID, SNC_REG_SW_DIV, SNC_REG_REF_DIV, SNC_REG_DIR_LO,
            SNC_REG_DIR_HI, SNC_REG_RSV_A, SNC_REG_RSV_B, SNC_REG_DEBUG_SRC};
        logic [31:0] msk [8] = '{SNC_LOW16_MASK, SNC_LOW16_MASK, SNC_LOW16_MASK, 32'hffff_ffff,
            32'hffff_ffff, SNC_RSV_MASK, SNC_RSV_MASK, SNC_DBG_MASK};
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b1, regs[i], 32'hffff_ffff, 1'b1);
            rdchk(regs[i], msk[i], 1'b1);
        end
        check("nodeId", 32'(nodeId), 32'h0000_ffff);
        check("clkDivs", {switchClkDiv, refClkDiv}, 32'hffff_ffff);
        acc(1'b1, SNC_REG_IDENT, 32'h0, 1'b0);
        rdchk(SNC_REG_IDENT, {8'h00, 8'ha5, REV, VER}, 1'b1);
        rdchk(8'h02, 32'h0, 1'b0);
        acc(1'b1, 8'h03, 32'h1, 1'b0);
    endtask : t_masks

    task automatic t_pll();
        // all ones sets bit 30, allowed here as no real clock change follows
        acc(1'b1, SNC_REG_PLL, 32'hffff_ffff, 1'b1);
        check("pllEvent", 32'(pllEvent), 32'h13);
        check("pllSettings", pllSettings, SNC_PLL_MASK);
        acc(1'b1, SNC_REG_PLL, 32'h0eea_bcaa, 1'b1);
        check("pllEvent", 32'(pllEvent), 32'h1c);
        rdchk(SNC_REG_PLL, 32'h028a_bc2a, 1'b1);
        check("pllEvent", 32'(pllEvent), 32'h0);
    endtask : t_pll

    task automatic t_header();
        acc(1'b1, SNC_REG_CONFIG, 32'h1, 1'b1);
        check("headerOneByte", 32'(headerOneByte), 32'h1);
        acc(1'b1, SNC_REG_CONFIG, 32'h7fff_fefe, 1'b1);
        rdchk(SNC_REG_CONFIG, 32'h0, 1'b1);
        check("headerOneByte", 32'(headerOneByte), 32'h0);
    endtask : t_header

    task automatic t_route();
        acc(1'b1, SNC_REG_NODE_ID, 32'h1234, 1'b1);
        acc(1'b1, SNC_REG_DIR_LO, 32'h7654_3210, 1'b1);
        acc(1'b1, SNC_REG_DIR_HI, 32'hfedc_ba98, 1'b1);
        for (int d = 0; d < 17; d++)
        begin
            // flips bit d and all below; d of 16 means no mismatch
            routeDestId = (d == 16) ? 16'h1234 : 16'h1234 ^ ((16'h2 << d) - 16'h1);
            @(negedge sys_clk);
            @(negedge sys_clk);
            check("route", {routeLocal, 27'h0, routeDir}, (d == 16) ? 32'h8000_0000 : 32'(d));
        end
    endtask : t_route

    task automatic t_debug();
        dbgEvtProc0 = 1'b1;
        @(negedge sys_clk);
        dbgEvtProc0 = 1'b0;
        rdchk(SNC_REG_DEBUG_SRC, 32'h11, 1'b1);
        dbgEvtProc1 = 1'b1;
        @(negedge sys_clk);
        dbgEvtProc1 = 1'b0;
        rdchk(SNC_REG_DEBUG_SRC, 32'h12, 1'b1);
    endtask : t_debug

    task automatic t_lock();
        acc(1'b1, SNC_REG_CONFIG, 32'h100, 1'b1);
        acc(1'b1, SNC_REG_PLL, 32'h0, 1'b0);
        check("pllBlocked", pllSettings ^ 32'(pllEvent), 32'h028a_bc2a);
        acc(1'b1, SNC_REG_NODE_ID, 32'h55, 1'b1);
        acc(1'b1, SNC_REG_CONFIG, 32'h8000_0100, 1'b1);
        acc(1'b1, SNC_REG_NODE_ID, 32'haa, 1'b0);
        acc(1'b1, SNC_REG_REF_DIV, 32'h9, 1'b0);
        acc(1'b1, SNC_REG_CONFIG, 32'h0, 1'b0);
        rdchk(SNC_REG_CONFIG, 32'h8000_0100, 1'b1);
        rdchk(SNC_REG_NODE_ID, 32'h55, 1'b1);
        check("refClkDiv", 32'(refClkDiv), 32'hffff);
    endtask : t_lock

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        do_reset();
        t_reset();
        t_masks();
        t_pll();
        t_header();
        t_route();
        t_debug();
        t_lock();
        // second reset in mid-run clears the lock
        do_reset();
        rdchk(SNC_REG_CONFIG, 32'h0, 1'b1);
        rdchk(SNC_REG_NODE_ID, 32'h0, 1'b1);
        rdchk(SNC_REG_IDENT, {8'h00, 8'h3c, REV, VER}, 1'b1);
        end_of_test();
    end

    // tests take some 170 cycles; limit is 10000
    initial
    begin
        #400000;
        num_errors++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
